// ==== rtl/boot_opt_cfg.svh ====
// Constants for the boot select and option configuration block.
// Assumes one 25 MHz system clock and a synchronous active-low reset.
// How it works
// - Boot from application flash by default.
// - strap_b, strap_c low and bit4 low reboot.
// - strap_a low and bit5 low reboot.
// - Lock bit zero blocks flash and option access.
// - Inhibit zero keeps external table reads external.
// - Internal table reads may reach everything.
// - Encryption on encodes port 0 data.
// - Full-chip erase clears encryption enable; reset reloads it from bit2.
// - Option bit selects 6T or 12T clocking.
`ifndef BOOT_OPT_CFG_SVH
`define BOOT_OPT_CFG_SVH
`define OPT_LOCK_BIT 0
`define OPT_INHIBIT_BIT 1
`define OPT_ENCRYPT_BIT 2
`define OPT_CLK6T_BIT 3
`define OPT_REBOOT_BC_BIT 4
`define OPT_REBOOT_A_BIT 5
`define OPT_GAIN_BIT 7
`define OPT_RESET_VALUE 8'hff
`define SETTLE_CYCLES 4'h4
`endif

// ==== rtl/boot_opt_pkg.sv ====
// Types shared by the boot select and option configuration block.
// Assumes nothing beyond a SystemVerilog compiler.
package boot_opt_pkg;
    typedef enum logic [1:0] {
        ST_SETTLE = 2'b00,
        ST_SAMPLE = 2'b01,
        ST_RUN = 2'b11
    } boot_state_t;
    typedef struct packed {
        logic strap_a;
        logic strap_b;
        logic strap_c;
    } strap_t;
    typedef struct packed {
        logic reboot;
        logic clk_6t;
        logic half_gain;
    } boot_cfg_t;
endpackage

// ==== rtl/strap_sync.sv ====
// Two-stage synchroniser for a group of pin levels.
// Assumes the pins are asynchronous to clk_sys.
`timescale 1ns/1ps
module strap_sync #(
    parameter int WIDTH = 3
) (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic rst_n,
    // Pins in, synchronised levels out
    input wire logic [WIDTH-1:0] pin_in,
    output logic [WIDTH-1:0] pin_sync
);
    logic [WIDTH-1:0] meta_r;
    initial begin
        if (WIDTH < 1) begin
            $error("strap_sync width must be at least one");
        end
    end
    // Reset to ones: a released strap reads high, so reset never reboots.
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            meta_r <= {WIDTH{1'b1}};
            pin_sync <= {WIDTH{1'b1}};
        end else begin
            meta_r <= pin_in;
            pin_sync <= meta_r;
        end
    end
endmodule // strap_sync

// ==== rtl/boot_select.sv ====
// Boot source selection, option bit decode and code protection gating.
// Assumes strap pins are asynchronous and option bits come from the
// non-volatile store, stable after reset; flash control is on clk_sys.
// Assumes the core and the programmer drive their requests on clk_sys,
// so only the straps need synchronising.
`timescale 1ns/1ps
`include "boot_opt_cfg.svh"
module boot_select
    import boot_opt_pkg::*;
#(
    parameter int SETTLE = `SETTLE_CYCLES
) (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic rst_n,
    // Strap pins and non-volatile option byte
    input wire strap_t strap_in,
    input wire logic [7:0] option_bits,
    // Table read request from the core
    input wire logic table_read_req,
    input wire logic fetch_internal,
    input wire logic addr_internal,
    // Flash and option access requests from a programmer
    input wire logic access_req,
    input wire logic chip_erase_req,
    input wire logic encrypt_set_req,
    // Port 0 data path
    input wire logic [7:0] port0_data,
    input wire logic [7:0] encrypt_key,
    // Boot configuration
    output boot_cfg_t boot_cfg,
    output logic cfg_valid,
    // Access results
    output logic table_read_allow,
    output logic access_grant,
    output logic [7:0] port0_out,
    output logic encrypt_on
);
    // The settle count and the state give one sampling point per reset.
    boot_state_t state_r;
    strap_t strap_s;
    logic [3:0] settle_r;
    logic encrypt_r;
    logic unused_enc;

    // The synchroniser needs two edges before it shows pin levels, and the
    // settle counter is four bits wide, so it cannot count past 15.
    if (SETTLE < 2 || SETTLE > 15) begin : g_bad_settle
        $error("SETTLE must lie between 2 and 15");
    end

    // Straps come from board switches, so they cross into clk_sys here.
    // The synchroniser resets high, like an open strap, so a reset alone
    // never selects the loader flash.
    strap_sync #(
        .WIDTH(3)
    ) u_sync (
        .clk_sys(clk_sys),
        .rst_n(rst_n),
        .pin_in(strap_in),
        .pin_sync(strap_s)
    );

    // State decodes used by several processes.
    function automatic logic is_sample(input boot_state_t s);
        is_sample = (s == ST_SAMPLE);
    endfunction

    function automatic logic is_settle(input boot_state_t s);
        is_settle = (s == ST_SETTLE);
    endfunction

    // Either strap group, with its own enable low, picks the loader flash.
    function automatic logic reboot_decode(input strap_t s,
                                           input logic [7:0] o);
        logic via_bc;
        logic via_a;
        via_bc = !s.strap_b && !s.strap_c && !o[`OPT_REBOOT_BC_BIT];
        via_a = !s.strap_a && !o[`OPT_REBOOT_A_BIT];
        reboot_decode = via_bc || via_a;
    endfunction

    // Code that runs from inside may read anywhere. Code that runs from
    // outside reaches inside memory only while the inhibit bit is high,
    // which keeps a foreign program from dumping the internal code.
    function automatic logic table_gate(input logic req,
                                        input logic from_inside,
                                        input logic to_inside,
                                        input logic inhibit_n);
        table_gate = req && (from_inside || !to_inside || inhibit_n);
    endfunction

    // A programmer gets through only once the option byte has been taken
    // in and while the lock bit is still high.
    function automatic logic access_open(input logic req,
                                         input logic sampled,
                                         input logic lock_n);
        access_open = req && sampled && lock_n;
    endfunction

    // The cipher is a plain XOR with a key input; a stronger scheme can
    // replace this function without touching the rest of the block.
    function automatic logic [7:0] port0_encode(input logic enable,
                                                input logic [7:0] data,
                                                input logic [7:0] key);
        port0_encode = enable ? (data ^ key) : data;
    endfunction

    // The settle counter lets the synchroniser fill before the sample.
    // It stops in the later states, so it never wraps during a run.
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            settle_r <= 4'h0;
        end else if (is_settle(state_r)) begin
            settle_r <= settle_r + 4'h1;
        end
    end

    // Only a reset leaves ST_RUN, so the boot choice is never resampled.
    // sample once
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            state_r <= ST_SETTLE;
        end else begin
            unique case (state_r)
                ST_SETTLE: begin
                    // Both synchroniser flops hold pin levels by now.
                    if (settle_r == 4'(SETTLE - 1)) begin
                        state_r <= ST_SAMPLE;
                    end
                end
                ST_SAMPLE: begin
                    // Straps and option byte are taken in this one cycle.
                    state_r <= ST_RUN;
                end
                ST_RUN: begin
                    state_r <= ST_RUN;
                end
                default: begin
                    // The unused code restarts the settle, never the run.
                    state_r <= ST_SETTLE;
                end
            endcase
        end
    end

    // Reset clears reboot, so the application flash is the safe default.
    // default application flash
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            boot_cfg <= '0;
        end else if (is_sample(state_r)) begin
            boot_cfg.reboot <= reboot_decode(strap_s, option_bits);
            boot_cfg.clk_6t <= !option_bits[`OPT_CLK6T_BIT];
            boot_cfg.half_gain <= !option_bits[`OPT_GAIN_BIT];
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            cfg_valid <= 1'b0;
        end else if (is_sample(state_r)) begin
            cfg_valid <= 1'b1;
        end
    end

    // The enable reloads from the option byte at each sample, so a set
    // made by programming lasts only until the next reset re-reads it.
    // erase only clears
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            encrypt_r <= 1'b0;
        end else if (chip_erase_req) begin
            encrypt_r <= 1'b0;
        end else if (encrypt_set_req ||
                     (is_sample(state_r) &&
                      !option_bits[`OPT_ENCRYPT_BIT])) begin
            encrypt_r <= 1'b1;
        end
    end

    // A grant waits for the sample, so no access slips in during settle.
    // lock blocks access
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            access_grant <= 1'b0;
        end else begin
            access_grant <= access_open(access_req, cfg_valid,
                                        option_bits[`OPT_LOCK_BIT]);
        end
    end

    // The gate is evaluated every cycle; requests need no spacing.
    // inhibit gate, internal always
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            table_read_allow <= 1'b0;
        end else begin
            table_read_allow <= table_gate(table_read_req, fetch_internal,
                                           addr_internal,
                                           option_bits[`OPT_INHIBIT_BIT]);
        end
    end

    // The flag is registered beside the data, so both show the same
    // encryption state in the same cycle.
    // encode port 0
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            port0_out <= 8'h00;
            encrypt_on <= 1'b0;
        end else begin
            port0_out <= port0_encode(encrypt_r, port0_data, encrypt_key);
            encrypt_on <= encrypt_r;
        end
    end

    // Option bit 6 has no function here; it is read only so that the
    // whole byte is accounted for.
    assign unused_enc = option_bits[6];
endmodule // boot_select

// ==== dv/boot_select_sva.sv ====
// Port checker for boot_select, bound below.
// Assumes one clock and a synchronous active-low reset.
`timescale 1ns/1ps
module boot_select_sva
    import boot_opt_pkg::*;
(
    // Clock, reset and inputs
    input wire logic clk_sys, rst_n, table_read_req, fetch_internal,
    input wire logic addr_internal, access_req, chip_erase_req,
    input wire logic [7:0] option_bits, port0_data, encrypt_key,
    // Outputs
    input wire boot_cfg_t boot_cfg,
    input wire logic cfg_valid, table_read_allow, access_grant, encrypt_on,
    input wire logic [7:0] port0_out
);
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!rst_n);
    lock_blocks_a: assert property (access_req && !option_bits[0]
        |=> !access_grant) else $error("grant while locked");
    inhibit_ext_a: assert property (table_read_req && !option_bits[1]
        && !fetch_internal && addr_internal |=> !table_read_allow)
        else $error("external read reached internal");
    internal_read_a: assert property (table_read_req && fetch_internal
        |=> table_read_allow) else $error("internal read refused");
    encrypt_data_a: assert property (encrypt_on && $past(encrypt_on)
        |-> port0_out == ($past(port0_data) ^ $past(encrypt_key)))
        else $error("port 0 not encoded");
    erase_clears_a: assert property (chip_erase_req
        |-> ##2 !encrypt_on) else $error("erase kept encryption");
    grant_open_a: assert property (access_req && option_bits[0]
        && cfg_valid |=> access_grant) else $error("open access refused");
    plain_data_a: assert property ($past(rst_n) && !encrypt_on
        |-> port0_out == $past(port0_data)) else $error("port 0 altered");
    gain_clock_a: assert property (cfg_valid |->
        boot_cfg.half_gain == !option_bits[7]
        && boot_cfg.clk_6t == !option_bits[3]) else $error("gain or mode");
    cfg_hold_a: assert property (cfg_valid |=> cfg_valid
        && $stable(boot_cfg)) else $error("boot choice moved");
    default_boot_a: assert property (cfg_valid
        && option_bits[5:4] == 2'h3 |-> !boot_cfg.reboot)
        else $error("reboot without enable");
endmodule // boot_select_sva
bind boot_select boot_select_sva u_sva(.clk_sys(clk_sys), .rst_n(rst_n),
    .table_read_req(table_read_req), .fetch_internal(fetch_internal),
    .addr_internal(addr_internal), .access_req(access_req),
    .chip_erase_req(chip_erase_req), .option_bits(option_bits),
    .port0_data(port0_data), .encrypt_key(encrypt_key),
    .boot_cfg(boot_cfg), .cfg_valid(cfg_valid),
    .table_read_allow(table_read_allow), .access_grant(access_grant),
    .encrypt_on(encrypt_on), .port0_out(port0_out));

// ==== dv/strap_board.sv ====
// Board strap model: buttons held through reset, released once booted.
// Assumes the pattern is set before reset is released.
`timescale 1ns/1ps
module strap_board
    import boot_opt_pkg::*;
(
    input wire logic [2:0] pattern,
    input wire logic cfg_valid,
    output strap_t strap_in
);
    // Released buttons read back inverted, so a late resample would show.
    assign strap_in = cfg_valid ? ~pattern : pattern;
endmodule // strap_board

// ==== dv/boot_select_tb_top.sv ====
// Bench for boot_select: straps and option bytes fixed for two resets, then random, one set per reset.
// Assumes the strap board model and the checker are compiled first.
`timescale 1ns/1ps
module boot_select_tb_top;
    import boot_opt_pkg::*;
    logic clk_sys = 0, rst_n = 0, table_read_req = 0, fetch_internal = 0;
    logic addr_internal = 0, access_req = 0, chip_erase_req = 0;
    logic encrypt_set_req = 0, cfg_valid, table_read_allow, access_grant;
    logic encrypt_on;
    logic [7:0] option_bits = 8'hff, port0_data = 0, encrypt_key = 0;
    logic [7:0] port0_out;
    logic [2:0] pattern = 0;
    logic [31:0] r;
    strap_t strap_in;
    boot_cfg_t boot_cfg;
    int mismatches = 0, checks_done = 0, seed = 32'hcc86, t, n;
    strap_board u_board(.pattern, .cfg_valid, .strap_in);
    boot_select u_dut(.clk_sys(clk_sys), .rst_n(rst_n), .strap_in(strap_in),
        .option_bits(option_bits), .table_read_req(table_read_req),
        .fetch_internal(fetch_internal), .addr_internal(addr_internal),
        .access_req(access_req), .chip_erase_req(chip_erase_req),
        .encrypt_set_req(encrypt_set_req), .port0_data(port0_data),
        .encrypt_key(encrypt_key), .boot_cfg(boot_cfg),
        .cfg_valid(cfg_valid), .table_read_allow(table_read_allow),
        .access_grant(access_grant), .port0_out(port0_out),
        .encrypt_on(encrypt_on));
    task automatic chk_byte(string nm, logic [7:0] e, logic [7:0] g);
        checks_done++;
        if (g !== e) begin
            mismatches++;
            $display("FAIL %s exp %h got %h", nm, e, g);
        end
    endtask
    task automatic chk_bit(string nm, logic e, logic g);
        chk_byte(nm, {7'h0, e}, {7'h0, g});
    endtask
    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", checks_done, mismatches);
        if (mismatches == 0 && checks_done > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask
    function automatic logic [7:0] exp_cfg(logic [2:0] s, logic [7:0] o);
        return {5'h0, (!s[1] && !s[0] && !o[4]) || (!s[2] && !o[5]),
            !o[3], !o[7]};
    endfunction
    initial forever #20 clk_sys = ~clk_sys;
    initial begin
        for (t = 0; t < 12; t++) begin
            r = $random(seed);
            rst_n <= 0;
            pattern <= t < 2 ? 3'h0 : r[10:8];
            option_bits <= t == 0 ? 8'hff : t == 1 ? 8'h04 : r[7:0];
            repeat (10) @(posedge clk_sys);
            rst_n <= 1;
            for (n = 0; n < 40 && cfg_valid !== 1'b1; n++) begin
                @(posedge clk_sys);
                #1;
            end
            chk_bit("cfg_valid", 1'b1, cfg_valid);
            if (n == 40) break;
            chk_byte("settle", 8'h05, 8'(n));
            chk_byte("boot", exp_cfg(pattern, option_bits),
                {5'h0, boot_cfg});
            repeat (20) begin
                @(posedge clk_sys);
                r = $random(seed);
                table_read_req <= r[3];
                fetch_internal <= r[2];
                addr_internal <= r[1];
                access_req <= r[0];
                @(posedge clk_sys);
                #1 chk_bit("allow", r[3] && (r[2] || !r[1] || option_bits[1]),
                    table_read_allow);
                chk_bit("grant", r[0] && option_bits[0], access_grant);
            end
            chk_byte("hold", exp_cfg(pattern, option_bits),
                {5'h0, boot_cfg});
            chk_bit("enc_opt", !option_bits[2], encrypt_on);
            @(posedge clk_sys);
            port0_data <= r[15:8];
            encrypt_key <= r[23:16];
            encrypt_set_req <= 1;
            @(posedge clk_sys);
            encrypt_set_req <= 0;
            repeat (2) @(posedge clk_sys);
            #1 chk_byte("p0", port0_data ^ encrypt_key, port0_out);
            @(posedge clk_sys);
            chip_erase_req <= 1;
            @(posedge clk_sys);
            chip_erase_req <= 0;
            @(posedge clk_sys);
            #1 chk_bit("enc_off", 1'b0, encrypt_on);
            chk_byte("p0_plain", port0_data, port0_out);
            @(posedge clk_sys);
        end
        tally_and_finish();
    end
endmodule // boot_select_tb_top
